//--- src_eq_model.sv
// cable equalizer and loop lock model at the far side of the reclocker
`timescale 1ns/100ps
module src_eq_model (
    input  wire logic       aclk,
    input  wire logic       data_on,
    input  wire logic       force_unlock,
    input  wire logic [7:0] lock_delay,
    output logic            serial_data,
    output logic            pll_locked
);
    logic [7:0] pat;
    logic [7:0] cnt;

    initial begin
        pat = 8'h00;
        cnt = 8'h00;
        serial_data = 1'b0;
        pll_locked = 1'b0;
    end

    // stopped data freezes at its last level, as a lost cable does
    always_ff @(posedge aclk) begin
        pat <= pat + 8'h01;
        if (data_on) begin
            serial_data <= pat[0] ^ pat[2];
        end
    end

    // the loop locks only after data has flowed lock_delay cycles
    always_ff @(posedge aclk) begin
        if (force_unlock) begin
            cnt <= 8'h00;
            pll_locked <= 1'b0;
        end else if (cnt == lock_delay) begin
            pll_locked <= 1'b1;
        end else if (data_on) begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule // src_eq_model

//--- src_pkg.sv
// shared constants and types for the sdi reclocker control block
// Overview of operation
// - silence low mutes both serial outputs
// - silence overrides forced and automatic bypass
// - silence input defaults to un-muted
// - skip select high passes data unretimed
// - skip low bypasses when unlocked or unsupported
// - skip select high holds lock indicator low
// - skip select defaults low, auto bypass
// - unlocked and unmuted means retiming bypassed
// - locked, unmuted, skip low, rate supported means retiming
// - lock high only with data and loop lock
// - rate flag high means 270 Mbps data
// - rate flag registered, valid only while locked
// - rate flag held low while unlocked
// - rate flag settles one period after lock edge
// - lock drops within 1 ms of data loss
// - clock select picks clock or second data
// - clock select defaults low, second data
// - both serial outputs always driven
// - clock on second output muted in bypass
// - muted legs sit at fixed opposite levels
// - lock within 15 ms of first transition
package src_pkg;

    // timing, in ns as printed, and derived cycle counts
    localparam int CLK_PERIOD_NS    = 40;
    localparam int LOCK_DROP_NS     = 1000000;
    localparam int ACQ_TIME_NS      = 15000000;
    localparam int RATE_SETTLE_NS   = 37;
    // longest times round down, least times round up
    localparam int LOCK_DROP_CYC    = LOCK_DROP_NS / CLK_PERIOD_NS;
    localparam int ACQ_TIME_CYC     = ACQ_TIME_NS / CLK_PERIOD_NS;
    localparam int RATE_SETTLE_CYC  =
        (RATE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // register map, byte addresses
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;

    // control register fields
    localparam int CTRL_MUTE_BIT    = 0;
    localparam int CTRL_BYPASS_BIT  = 1;
    localparam int CTRL_CLKSEL_BIT  = 2;
    localparam logic [2:0] CTRL_RST = 3'h0;

    // status register fields
    localparam int STAT_LOCK_BIT    = 0;
    localparam int STAT_RATE_BIT    = 1;
    localparam int STAT_BYPASS_BIT  = 2;
    localparam int STAT_MUTED_BIT   = 3;
    localparam int STAT_CLKSEL_BIT  = 4;
    localparam int STAT_ACQLATE_BIT = 5;

    // synchroniser order: {clock select, skip, silence_n}
    localparam logic [2:0] SYNC_RST = 3'h1;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SRC_LK_IDLE   = 2'b00,
        SRC_LK_ACQ    = 2'b01,
        SRC_LK_LOCKED = 2'b10
    } src_lock_t;

endpackage

//--- src_reclocker_ctrl.sv
// control, lock and output logic of the sdi reclocker
`timescale 1ns/100ps
module src_reclocker_ctrl #(
    parameter int LOCK_DROP_CYCLES = src_pkg::LOCK_DROP_CYC,
    parameter int ACQ_TIME_CYCLES  = src_pkg::ACQ_TIME_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        output_silence_n,
    input  wire logic        retime_skip_select,
    input  wire logic        second_output_clock_select,
    input  wire logic        serial_video_input,
    input  wire logic        loop_pll_locked,
    input  wire logic        rate_detect_270,
    input  wire logic        rate_supported,
    output logic             primary_serial_output_p,
    output logic             primary_serial_output_n,
    output logic             second_serial_output_p,
    output logic             second_serial_output_n,
    output logic             loop_lock_indicator,
    output logic             standard_rate_flag
);

    localparam int DROP_W = $clog2(LOCK_DROP_CYCLES + 1);
    localparam int ACQ_W  = $clog2(ACQ_TIME_CYCLES + 1);

    // ---------------- register bus ----------------
    logic [2:0]  ctrl;
    logic        aw_held;
    logic        w_held;
    logic [3:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (aw_held && w_held) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (aw_held && w_held) begin
            w_held <= 1'b0;
        end
    end

    // commit once both halves are held, then answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl         <= src_pkg::CTRL_RST;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= src_pkg::RESP_OKAY;
        end else if (aw_held && w_held) begin
            s_axi_bvalid <= 1'b1;
            if (aw_addr == src_pkg::ADDR_CTRL) begin
                s_axi_bresp <= src_pkg::RESP_OKAY;
                if (w_strb[0]) begin
                    ctrl <= w_data[2:0];
                end
            end else if (aw_addr == src_pkg::ADDR_STATUS) begin
                s_axi_bresp <= src_pkg::RESP_OKAY;
            end else begin
                s_axi_bresp <= src_pkg::RESP_SLVERR;
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    logic [31:0] status_word;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= src_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            if (s_axi_araddr == src_pkg::ADDR_CTRL) begin
                s_axi_rdata <= {29'h0, ctrl};
                s_axi_rresp <= src_pkg::RESP_OKAY;
            end else if (s_axi_araddr == src_pkg::ADDR_STATUS) begin
                s_axi_rdata <= status_word;
                s_axi_rresp <= src_pkg::RESP_OKAY;
            end else begin
                s_axi_rdata <= 32'h0;
                s_axi_rresp <= src_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------- control pins ----------------
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;

    // reset values stand in for the pull-up and pull-downs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta <= src_pkg::SYNC_RST;
            pin_sync <= src_pkg::SYNC_RST;
        end else begin
            pin_meta <= {second_output_clock_select, retime_skip_select,
                         output_silence_n};
            pin_sync <= pin_meta;
        end
    end

    logic silence_n_s;
    logic skip_s;
    logic clk_sel_s;

    assign silence_n_s = pin_sync[0] & ~ctrl[src_pkg::CTRL_MUTE_BIT];
    assign skip_s      = pin_sync[1] | ctrl[src_pkg::CTRL_BYPASS_BIT];
    assign clk_sel_s   = pin_sync[2] | ctrl[src_pkg::CTRL_CLKSEL_BIT];

    // ---------------- activity and lock ----------------
    logic              din_q;
    logic              din_q2;
    logic              din_edge;
    logic [DROP_W-1:0] idle_cnt;
    logic              data_lost;

    assign din_edge  = din_q ^ din_q2;
    assign data_lost = idle_cnt == DROP_W'(LOCK_DROP_CYCLES);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            din_q  <= 1'b0;
            din_q2 <= 1'b0;
        end else begin
            din_q  <= serial_video_input;
            din_q2 <= din_q;
        end
    end

    // counts cycles with no input transition, saturating
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idle_cnt <= '0;
        end else if (din_edge) begin
            idle_cnt <= '0;
        end else if (!data_lost) begin
            idle_cnt <= idle_cnt + DROP_W'(1);
        end
    end

    src_pkg::src_lock_t lock_state;
    src_pkg::src_lock_t next_lock_state;
    logic [ACQ_W-1:0]   acq_cnt;
    logic               acq_late;
    logic               in_lock;

    assign in_lock  = lock_state == src_pkg::SRC_LK_LOCKED;
    assign acq_late = acq_cnt == ACQ_W'(ACQ_TIME_CYCLES);

    always_comb begin
        next_lock_state = lock_state;
        case (lock_state)
            src_pkg::SRC_LK_IDLE: begin
                if (din_edge) begin
                    next_lock_state = src_pkg::SRC_LK_ACQ;
                end
            end
            src_pkg::SRC_LK_ACQ: begin
                if (data_lost) begin
                    next_lock_state = src_pkg::SRC_LK_IDLE;
                end else if (loop_pll_locked) begin
                    next_lock_state = src_pkg::SRC_LK_LOCKED;
                end
            end
            src_pkg::SRC_LK_LOCKED: begin
                if (data_lost) begin
                    next_lock_state = src_pkg::SRC_LK_IDLE;
                end else if (!loop_pll_locked) begin
                    next_lock_state = src_pkg::SRC_LK_ACQ;
                end
            end
            default: begin
                next_lock_state = src_pkg::SRC_LK_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_state <= src_pkg::SRC_LK_IDLE;
        end else begin
            lock_state <= next_lock_state;
        end
    end

    // time spent in the acquire state; flags a late acquisition
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acq_cnt <= '0;
        end else if (lock_state != src_pkg::SRC_LK_ACQ) begin
            acq_cnt <= '0;
        end else if (!acq_late) begin
            acq_cnt <= acq_cnt + ACQ_W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loop_lock_indicator <= 1'b0;
        end else begin
            loop_lock_indicator <= in_lock && !skip_s;
        end
    end

    // lock indicator and 270 detect, registered one cycle late; low while unlocked
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            standard_rate_flag <= 1'b0;
        end else begin
            standard_rate_flag <= loop_lock_indicator
                                  && rate_detect_270;
        end
    end

    // ---------------- data path ----------------
    logic bypass_act;
    logic retimed;
    logic rclk;
    logic data_sel;
    logic sec_mute;

    assign bypass_act = skip_s || !loop_lock_indicator
                        || !rate_supported;
    assign data_sel   = bypass_act ? serial_video_input : retimed;
    assign sec_mute   = !silence_n_s
                        || (clk_sel_s && bypass_act);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            retimed <= 1'b0;
            rclk    <= 1'b0;
        end else begin
            retimed <= din_q;
            rclk    <= ~rclk;
        end
    end

    // muting wins over every bypass choice; legs never float
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            primary_serial_output_p <= 1'b0;
            primary_serial_output_n <= 1'b1;
        end else if (!silence_n_s) begin
            primary_serial_output_p <= 1'b0;
            primary_serial_output_n <= 1'b1;
        end else begin
            primary_serial_output_p <= data_sel;
            primary_serial_output_n <= ~data_sel;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            second_serial_output_p <= 1'b0;
            second_serial_output_n <= 1'b1;
        end else if (sec_mute) begin
            second_serial_output_p <= 1'b0;
            second_serial_output_n <= 1'b1;
        end else begin
            second_serial_output_p <= clk_sel_s ? rclk
                                                : data_sel;
            second_serial_output_n <= clk_sel_s ? ~rclk : ~data_sel;
        end
    end

    always_comb begin
        status_word = 32'h0;
        status_word[src_pkg::STAT_LOCK_BIT]    = loop_lock_indicator;
        status_word[src_pkg::STAT_RATE_BIT]    = standard_rate_flag;
        status_word[src_pkg::STAT_BYPASS_BIT]  = bypass_act;
        status_word[src_pkg::STAT_MUTED_BIT]   = !silence_n_s;
        status_word[src_pkg::STAT_CLKSEL_BIT]  = clk_sel_s;
        status_word[src_pkg::STAT_ACQLATE_BIT] = acq_late;
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_mute_all;
        !silence_n_s |=> !primary_serial_output_p && primary_serial_output_n
            && !second_serial_output_p && second_serial_output_n;
    endproperty
    a_mute_all: assert property (p_mute_all)
        else $error("outputs not muted while silence active");

    property p_mute_over_skip;
        (!silence_n_s && skip_s) |=> !primary_serial_output_p;
    endproperty
    a_mute_over_skip: assert property (p_mute_over_skip)
        else $error("bypass overrode silence");

    property p_pin_defaults;
        $past(!aresetn) |-> pin_sync == src_pkg::SYNC_RST;
    endproperty
    a_pin_defaults: assert property (p_pin_defaults)
        else $error("control pins left reset at wrong default");

    property p_forced_bypass;
        (skip_s && silence_n_s) |=>
            primary_serial_output_p == $past(serial_video_input);
    endproperty
    a_forced_bypass: assert property (p_forced_bypass)
        else $error("forced bypass did not pass raw data");

    property p_retiming;
        (!skip_s && loop_lock_indicator && rate_supported && silence_n_s)
            |=> primary_serial_output_p == $past(retimed);
    endproperty
    a_retiming: assert property (p_retiming)
        else $error("locked supported data not retimed");

    property p_skip_no_lock;
        skip_s |=> !loop_lock_indicator;
    endproperty
    a_skip_no_lock: assert property (p_skip_no_lock)
        else $error("lock indicator high during forced bypass");

    property p_unlocked_bypass;
        (!loop_lock_indicator && silence_n_s) |=>
            primary_serial_output_p == $past(serial_video_input);
    endproperty
    a_unlocked_bypass: assert property (p_unlocked_bypass)
        else $error("unlocked data was retimed");

    property p_lock_cause;
        $rose(loop_lock_indicator) |-> $past(in_lock)
            && $past(loop_pll_locked, 2) && !$past(skip_s);
    endproperty
    a_lock_cause: assert property (p_lock_cause)
        else $error("lock indicator rose without loop lock");

    property p_rate_valid;
        standard_rate_flag |-> $past(loop_lock_indicator)
            && $past(rate_detect_270);
    endproperty
    a_rate_valid: assert property (p_rate_valid)
        else $error("rate flag high without lock");

    property p_rate_settle;
        $fell(loop_lock_indicator) |=> !standard_rate_flag;
    endproperty
    a_rate_settle: assert property (p_rate_settle)
        else $error("rate flag not cleared one cycle after lock drop");

    property p_drop;
        data_lost |=> !in_lock ##1 !loop_lock_indicator;
    endproperty
    a_drop: assert property (p_drop)
        else $error("lock held after loss of input data");

    property p_clock_out;
        (clk_sel_s && !bypass_act && silence_n_s) |=>
            second_serial_output_p == $past(rclk);
    endproperty
    a_clock_out: assert property (p_clock_out)
        else $error("second output not carrying recovered clock");

    property p_clock_mute;
        (clk_sel_s && bypass_act) |=>
            !second_serial_output_p && second_serial_output_n;
    endproperty
    a_clock_mute: assert property (p_clock_mute)
        else $error("clock output not muted in bypass");

endmodule // src_reclocker_ctrl

//--- tb_top.sv
// self-checking bench for the reclocker control block
`timescale 1ns/100ps
module tb_top;
    localparam int LDC = 20;
    localparam int ACQ = 50;
    // rows: {silence_n, skip, clksel, rate_ok, rate_270, lock, rate, pm, sm}
    localparam logic [8:0] ROWS [9] = '{9'h13C, 9'h03F, 9'h1B0, 9'h1F1,
        9'h0F3, 9'h17C, 9'h15D, 9'h128, 9'h11C};
    logic        aclk, aresetn;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp;
    logic        sil, skip, csel, rs, r270, tie, sil_pin;
    logic        din, pll, data_on, unl;
    logic [7:0]  ldly;
    logic        pp, pn, sp, sn, lock, rate;
    int          mismatches, samples_checked, cycles, n;

    assign sil_pin = tie ? lock : sil;

    src_reclocker_ctrl #(.LOCK_DROP_CYCLES(LDC), .ACQ_TIME_CYCLES(ACQ)) i_dut (
        .aclk                       (aclk),
        .aresetn                    (aresetn),
        .s_axi_awaddr               (awaddr),
        .s_axi_awvalid              (awvalid),
        .s_axi_awready              (awready),
        .s_axi_wdata                (wdata),
        .s_axi_wstrb                (wstrb),
        .s_axi_wvalid               (wvalid),
        .s_axi_wready               (wready),
        .s_axi_bresp                (bresp),
        .s_axi_bvalid               (bvalid),
        .s_axi_bready               (bready),
        .s_axi_araddr               (araddr),
        .s_axi_arvalid              (arvalid),
        .s_axi_arready              (arready),
        .s_axi_rdata                (rdata),
        .s_axi_rresp                (rresp),
        .s_axi_rvalid               (rvalid),
        .s_axi_rready               (rready),
        .output_silence_n           (sil_pin),
        .retime_skip_select         (skip),
        .second_output_clock_select (csel),
        .serial_video_input         (din),
        .loop_pll_locked            (pll),
        .rate_detect_270            (r270),
        .rate_supported             (rs),
        .primary_serial_output_p    (pp),
        .primary_serial_output_n    (pn),
        .second_serial_output_p     (sp),
        .second_serial_output_n     (sn),
        .loop_lock_indicator        (lock),
        .standard_rate_flag         (rate)
    );

    src_eq_model i_eq (
        .aclk         (aclk),
        .data_on      (data_on),
        .force_unlock (unl),
        .lock_delay   (ldly),
        .serial_data  (din),
        .pll_locked   (pll)
    );

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic end_sim;
        $display("mismatches %0d samples_checked %0d", mismatches,
                 samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            end_sim;
        end
    end

    task automatic cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask

    task automatic axw(input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] st, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", 32'(er), 32'(bresp));
    endtask

    task automatic axr(input logic [3:0] a, input logic [31:0] ed,
                       input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk("rdata", ed, rdata);
        chk("rresp", 32'(er), 32'(rresp));
    endtask

    // muted means p low, n high every cycle; live means the p leg moves
    task automatic outs(input logic epm, input logic esm);
        logic pm, sm, pt, st, cp, p0, s0;
        pm = 1'b1;
        sm = 1'b1;
        pt = 1'b0;
        st = 1'b0;
        cp = 1'b1;
        @(posedge aclk);
        p0 = pp;
        s0 = sp;
        repeat (8) begin
            @(posedge aclk);
            pm = pm & ~pp & pn;
            sm = sm & ~sp & sn;
            pt = pt | (pp ^ p0);
            st = st | (sp ^ s0);
            cp = cp & (pp ^ pn) & (sp ^ sn);
            p0 = pp;
            s0 = sp;
        end
        chk("pri_state", 32'({epm, ~epm}), 32'({pm, pt}));
        chk("sec_state", 32'({esm, ~esm}), 32'({sm, st}));
        chk("legs_opposite", 32'h1, 32'(cp));
    endtask

    task automatic wait_lock(input logic lv, input int lim);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (lock !== lv && n < lim);
    endtask

    initial begin
        {aresetn, awaddr, araddr, wdata, awvalid, wvalid} = '0;
        {bready, arvalid, rready, skip, csel, tie, data_on, unl} = '0;
        {sil, rs, r270} = 3'h7;
        wstrb = 4'hF;
        ldly = 8'h0A;
        mismatches = 0;
        samples_checked = 0;
        cycles = 0;
        cyc(19);
        chk("rst_outs", 32'h05, 32'({lock, rate, pp, pn, sp, sn}));
        @(posedge aclk);
        aresetn <= 1'b1;
        axr(src_pkg::ADDR_CTRL, 32'h0, src_pkg::RESP_OKAY);
        axr(src_pkg::ADDR_STATUS, 32'h4, src_pkg::RESP_OKAY);
        data_on <= 1'b1;
        wait_lock(1'b1, ACQ);
        chk("acq_lock", 32'h1, 32'(lock));
        chk("rate_settle", 32'h0, 32'(rate));
        @(posedge aclk);
        chk("rate_valid", 32'h1, 32'(rate));
        for (int i = 0; i < 9; i++) begin
            {sil, skip, csel, rs, r270} <= ROWS[i][8:4];
            cyc(16);
            chk("lock", 32'(ROWS[i][3]), 32'(lock));
            chk("rate", 32'(ROWS[i][2]), 32'(rate));
            outs(ROWS[i][1], ROWS[i][0]);
        end
        rs <= 1'b1;
        axw(src_pkg::ADDR_CTRL, 32'h7, 4'hF, src_pkg::RESP_OKAY);
        axr(src_pkg::ADDR_CTRL, 32'h7, src_pkg::RESP_OKAY);
        cyc(6);
        chk("ctrl_lock", 32'h0, 32'(lock));
        outs(1'b1, 1'b1);
        axw(src_pkg::ADDR_CTRL, 32'h0, 4'hF, src_pkg::RESP_OKAY);
        axw(src_pkg::ADDR_CTRL, 32'h7, 4'h0, src_pkg::RESP_OKAY);
        axr(src_pkg::ADDR_CTRL, 32'h0, src_pkg::RESP_OKAY);
        axw(src_pkg::ADDR_STATUS, 32'hFF, 4'hF, src_pkg::RESP_OKAY);
        cyc(16);
        axr(src_pkg::ADDR_STATUS, 32'h3, src_pkg::RESP_OKAY);
        axw(4'h8, 32'h0, 4'hF, src_pkg::RESP_SLVERR);
        axr(4'hC, 32'h0, src_pkg::RESP_SLVERR);
        data_on <= 1'b0;
        cyc(LDC - 8);
        chk("lock_hold", 32'h1, 32'(lock));
        wait_lock(1'b0, 16);
        chk("lock_drop", 32'h0, 32'(lock));
        cyc(2);
        chk("rate_low", 32'h0, 32'(rate));
        ldly <= 8'h1E;
        data_on <= 1'b1;
        cyc(16);
        chk("relock", 32'h1, 32'(lock));
        tie <= 1'b1;
        unl <= 1'b1;
        cyc(8);
        chk("unlock", 32'h0, 32'(lock));
        outs(1'b1, 1'b1);
        cyc(ACQ + 10);
        axr(src_pkg::ADDR_STATUS, 32'h2C, src_pkg::RESP_OKAY);
        unl <= 1'b0;
        tie <= 1'b0;
        wait_lock(1'b1, ACQ);
        chk("slow_lock", 32'h1, 32'(lock));
        end_sim;
    end
endmodule // tb_top
